/* File: include/tcs_pkg.sv */
// package for the trap control and status register block
package tcs_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] TCS_ADDR_CTRL = 8'h00; // trap_control_and_status
  localparam logic [7:0] TCS_ADDR_IPL  = 8'h04; // cpu priority level
  localparam logic [7:0] TCS_ADDR_IMSK = 8'h08; // interrupt mask

  // field positions inside trap_control_and_status
  localparam int NEST_BIT   = 15;
  localparam int OVA_BIT    = 14;
  localparam int OVB_BIT    = 13;
  localparam int COVA_BIT   = 12;
  localparam int COVB_BIT   = 11;
  localparam int ACC_A_OVERFLOW_TRAP_EN_BIT  = 10;
  localparam int ACC_B_OVERFLOW_TRAP_EN_BIT  = 9;
  localparam int CATASTROPHIC_TRAP_EN_BIT  = 8;
  localparam int SHIFT_BIT  = 7;
  localparam int DIV0_BIT   = 6;
  localparam int DMA_BIT    = 5;
  localparam int MATH_BIT   = 4;
  localparam int ADDR_BIT   = 3;
  localparam int STK_BIT    = 2;
  localparam int OSC_BIT    = 1;

  // plain writable control bits versus sticky status flags
  localparam logic [15:0] CTRL_MASK   = 16'h8700;
  localparam logic [15:0] STATUS_MASK = 16'h78fe;
  localparam logic [15:0] TCS_RESET   = 16'h0000;
  localparam logic [2:0]  IPL_RESET   = 3'h0;
  localparam logic [15:0] IMSK_RESET  = 16'h0000;

  // trap events raised by the datapath and core, one cycle pulses
  typedef struct packed {
    logic accAOvf;     // ordinary overflow of accumulator a
    logic accBOvf;     // ordinary overflow of accumulator b
    logic accACat;     // catastrophic overflow of accumulator a
    logic accBCat;     // catastrophic overflow of accumulator b
    logic badShift;    // invalid accumulator shift
    logic divZero;     // divide by zero
    logic dmaFault;    // dma controller error
    logic addrFault;   // address error
    logic stackFault;  // stack error
    logic oscFault;    // oscillator failure
  } tcs_event_t;

  // trap requests toward the core
  typedef struct packed {
    logic mathTrap;    // math error trap
    logic dmaTrap;     // dma error trap
    logic addrTrap;    // address error trap
    logic stackTrap;   // stack error trap
    logic oscTrap;     // oscillator failure trap
  } tcs_trap_t;
endpackage

/* File: design/tcs_trap_ctrl.sv */
// trap control and status register with apb slave and interrupt
`timescale 1ns/10ps

module tcs_trap_ctrl (
  input  wire logic               mclk,        // system clock
  input  wire logic               rstn,        // async reset, active low
  input  wire logic               psel,        // apb select
  input  wire logic               penable,     // apb access phase
  input  wire logic               pwrite,      // apb direction
  input  wire logic [7:0]         paddr,       // apb byte address
  input  wire logic [31:0]        pwdata,      // apb write data
  output logic                    pready,      // apb ready
  output logic [31:0]             prdata,      // apb read data
  output logic                    pslverr,     // apb error
  input  wire tcs_pkg::tcs_event_t trapEvent,  // datapath events
  input  wire logic [2:0]         coreIpl,     // core priority load
  input  wire logic               coreIplLoad, // core updates level
  output tcs_pkg::tcs_trap_t      trapReq,     // trap requests
  output logic                    nestingDisable, // level copy of bit
  output logic [2:0]              cpuPriorityLevel, // current level
  output logic                    irq          // level interrupt
);

  logic [15:0] tcs_r;      // trap_control_and_status
  logic [15:0] tcs_nxt;
  logic [2:0]  ipl_r;      // cpu_priority_level
  logic [2:0]  ipl_nxt;
  logic [15:0] imsk_r;     // interrupt mask, same layout
  logic [15:0] imsk_nxt;
  logic [15:0] setVec;     // hardware set requests this cycle
  logic        acc;        // apb access edge
  logic        wrCtrl;     // write to control register
  logic        wrIpl;      // write to priority level
  logic        wrMsk;      // write to mask
  logic        mapped;     // address decodes to a register
  tcs_pkg::tcs_trap_t trapNxt;

  // single-cycle access phase: answer comes with penable
  assign acc     = psel & penable;
  assign mapped  = (paddr == tcs_pkg::TCS_ADDR_CTRL) ||
                   (paddr == tcs_pkg::TCS_ADDR_IPL) ||
                   (paddr == tcs_pkg::TCS_ADDR_IMSK);
  assign pready  = acc;
  assign pslverr = acc & ~mapped;   // unmapped address is an error
  assign wrCtrl  = acc & pwrite & (paddr == tcs_pkg::TCS_ADDR_CTRL);
  assign wrIpl   = acc & pwrite & (paddr == tcs_pkg::TCS_ADDR_IPL);
  assign wrMsk   = acc & pwrite & (paddr == tcs_pkg::TCS_ADDR_IMSK);

  // trap qualification and status set vector
  always_comb begin
    setVec  = 16'h0000;
    trapNxt = '0;
    // ordinary overflow traps only while their enable stands
    if (trapEvent.accAOvf && tcs_r[tcs_pkg::ACC_A_OVERFLOW_TRAP_EN_BIT]) begin
      setVec[tcs_pkg::OVA_BIT] = 1'b1;
      trapNxt.mathTrap = 1'b1;
    end
    if (trapEvent.accBOvf && tcs_r[tcs_pkg::ACC_B_OVERFLOW_TRAP_EN_BIT]) begin
      setVec[tcs_pkg::OVB_BIT] = 1'b1;
      trapNxt.mathTrap = 1'b1;
    end
    // one enable covers catastrophic overflow of both accumulators
    if (trapEvent.accACat && tcs_r[tcs_pkg::CATASTROPHIC_TRAP_EN_BIT]) begin
      setVec[tcs_pkg::COVA_BIT] = 1'b1;
      trapNxt.mathTrap = 1'b1;
    end
    if (trapEvent.accBCat && tcs_r[tcs_pkg::CATASTROPHIC_TRAP_EN_BIT]) begin
      setVec[tcs_pkg::COVB_BIT] = 1'b1;
      trapNxt.mathTrap = 1'b1;
    end
    if (trapEvent.badShift) begin
      setVec[tcs_pkg::SHIFT_BIT] = 1'b1;
      trapNxt.mathTrap = 1'b1;
    end
    if (trapEvent.divZero) begin
      setVec[tcs_pkg::DIV0_BIT] = 1'b1;
      trapNxt.mathTrap = 1'b1;
    end
    // any math cause also sets the summary flag
    setVec[tcs_pkg::MATH_BIT] = trapNxt.mathTrap;
    setVec[tcs_pkg::DMA_BIT]  = trapEvent.dmaFault;
    setVec[tcs_pkg::ADDR_BIT] = trapEvent.addrFault;
    setVec[tcs_pkg::STK_BIT]  = trapEvent.stackFault;
    setVec[tcs_pkg::OSC_BIT]  = trapEvent.oscFault;
    trapNxt.dmaTrap   = trapEvent.dmaFault;
    trapNxt.addrTrap  = trapEvent.addrFault;
    trapNxt.stackTrap = trapEvent.stackFault;
    trapNxt.oscTrap   = trapEvent.oscFault;
  end

  // next register values; hardware set wins over a software clear
  always_comb begin
    tcs_nxt  = tcs_r;
    ipl_nxt  = ipl_r;
    imsk_nxt = imsk_r;
    if (wrCtrl) begin
      // control bits take the written value, flags only clear on zero
      tcs_nxt = (pwdata[15:0] & tcs_pkg::CTRL_MASK) |
                (tcs_r & pwdata[15:0] & tcs_pkg::STATUS_MASK);
    end
    tcs_nxt = tcs_nxt | setVec;
    tcs_nxt[0] = 1'b0;
    // software write ignored while nesting is disabled
    if (wrIpl && !tcs_r[tcs_pkg::NEST_BIT]) begin
      ipl_nxt = pwdata[2:0];
    end
    // core's own priority update has precedence
    if (coreIplLoad) begin
      ipl_nxt = coreIpl;
    end
    if (wrMsk) begin
      imsk_nxt = pwdata[15:0] & tcs_pkg::STATUS_MASK;
    end
  end

  // registers, all zero after power-on reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tcs_r   <= tcs_pkg::TCS_RESET;
      ipl_r   <= tcs_pkg::IPL_RESET;
      imsk_r  <= tcs_pkg::IMSK_RESET;
      trapReq <= '0;
    end else begin
      tcs_r   <= tcs_nxt;
      ipl_r   <= ipl_nxt;
      imsk_r  <= imsk_nxt;
      trapReq <= trapNxt;
    end
  end

  // read mux; data is combinational on the access cycle
  always_comb begin
    prdata = 32'h0000_0000;
    if (acc && !pwrite) begin
      case (paddr)
        tcs_pkg::TCS_ADDR_CTRL: prdata = {16'h0000, tcs_r};
        tcs_pkg::TCS_ADDR_IPL:  prdata = {29'h0, ipl_r};
        tcs_pkg::TCS_ADDR_IMSK: prdata = {16'h0000, imsk_r};
        default:                prdata = 32'h0000_0000;
      endcase
    end
  end

  // nesting disable is a steering level toward the core
  assign nestingDisable   = tcs_r[tcs_pkg::NEST_BIT];
  assign cpuPriorityLevel = ipl_r;
  // level interrupt while any unmasked sticky flag is set
  assign irq = |(tcs_r & imsk_r & tcs_pkg::STATUS_MASK);

  // assertions, one rule each, on what this block drives
  // every property names its own clock and reset

  // the unimplemented low bit never holds a one
  AST_BIT0_ZERO: assert property (
    @(posedge mclk) disable iff (!rstn)
    tcs_r[0] == 1'b0)
    else $error("bit 0 not zero");

  // a control read shows zero in bit 0 and in the upper half
  AST_READ_LOW: assert property (
    @(posedge mclk) disable iff (!rstn)
    acc && !pwrite && (paddr == tcs_pkg::TCS_ADDR_CTRL)
    |-> (prdata[0] == 1'b0) && (prdata[31:16] == 16'h0000))
    else $error("control read shows unimplemented bits");

  // the nesting level output follows the written bit
  AST_NEST: assert property (
    @(posedge mclk) disable iff (!rstn)
    wrCtrl |=> nestingDisable == $past(pwdata[tcs_pkg::NEST_BIT]))
    else $error("nesting bit not written");

  // enabled overflow of a sets its flag and a math trap
  AST_OVA_EN: assert property (
    @(posedge mclk) disable iff (!rstn)
    trapEvent.accAOvf && tcs_r[tcs_pkg::ACC_A_OVERFLOW_TRAP_EN_BIT]
    |=> tcs_r[tcs_pkg::OVA_BIT] && trapReq.mathTrap)
    else $error("enabled a overflow not flagged");

  // enabled overflow of b sets its flag and a math trap
  AST_OVB_EN: assert property (
    @(posedge mclk) disable iff (!rstn)
    trapEvent.accBOvf && tcs_r[tcs_pkg::ACC_B_OVERFLOW_TRAP_EN_BIT]
    |=> tcs_r[tcs_pkg::OVB_BIT] && trapReq.mathTrap)
    else $error("enabled b overflow not flagged");

  // a disabled overflow of a leaves no flag behind
  AST_OVA_DIS: assert property (
    @(posedge mclk) disable iff (!rstn)
    !tcs_r[tcs_pkg::OVA_BIT] && !tcs_r[tcs_pkg::ACC_A_OVERFLOW_TRAP_EN_BIT]
    |=> !tcs_r[tcs_pkg::OVA_BIT])
    else $error("disabled a overflow flagged");

  // a disabled overflow of b leaves no flag behind
  AST_OVB_DIS: assert property (
    @(posedge mclk) disable iff (!rstn)
    !tcs_r[tcs_pkg::OVB_BIT] && !tcs_r[tcs_pkg::ACC_B_OVERFLOW_TRAP_EN_BIT] &&
    !(wrCtrl && pwdata[tcs_pkg::OVB_BIT])
    |=> !tcs_r[tcs_pkg::OVB_BIT])
    else $error("disabled b overflow flagged");

  // catastrophic overflow raises no trap without its enable
  AST_COV: assert property (
    @(posedge mclk) disable iff (!rstn)
    (trapEvent.accACat || trapEvent.accBCat) &&
    !tcs_r[tcs_pkg::CATASTROPHIC_TRAP_EN_BIT] |=> !$rose(trapReq.mathTrap) ||
    $past(trapEvent.badShift || trapEvent.divZero ||
          trapEvent.accAOvf || trapEvent.accBOvf))
    else $error("catastrophic trap while disabled");

  // enabled catastrophic overflow of a sets its flag
  AST_COVA_EN: assert property (
    @(posedge mclk) disable iff (!rstn)
    trapEvent.accACat && tcs_r[tcs_pkg::CATASTROPHIC_TRAP_EN_BIT]
    |=> tcs_r[tcs_pkg::COVA_BIT] && trapReq.mathTrap)
    else $error("catastrophic a not flagged");

  // enabled catastrophic overflow of b sets its flag
  AST_COVB_EN: assert property (
    @(posedge mclk) disable iff (!rstn)
    trapEvent.accBCat && tcs_r[tcs_pkg::CATASTROPHIC_TRAP_EN_BIT]
    |=> tcs_r[tcs_pkg::COVB_BIT] && trapReq.mathTrap)
    else $error("catastrophic b not flagged");

  // an invalid shift sets its cause and a math trap
  AST_SHIFT_SET: assert property (
    @(posedge mclk) disable iff (!rstn)
    trapEvent.badShift
    |=> tcs_r[tcs_pkg::SHIFT_BIT] && trapReq.mathTrap)
    else $error("shift cause not flagged");

  // divide by zero sets its cause and a math trap
  AST_DIV0_SET: assert property (
    @(posedge mclk) disable iff (!rstn)
    trapEvent.divZero
    |=> tcs_r[tcs_pkg::DIV0_BIT] && trapReq.mathTrap)
    else $error("divide cause not flagged");

  // dma and oscillator faults both land when they coincide
  AST_DMA_OSC: assert property (
    @(posedge mclk) disable iff (!rstn)
    trapEvent.dmaFault ##0 trapEvent.oscFault
    |=> tcs_r[tcs_pkg::DMA_BIT] && tcs_r[tcs_pkg::OSC_BIT])
    else $error("dma or osc flag missing");

  // the summary flag follows an invalid shift or a divide by zero
  AST_MATH_SUM: assert property (
    @(posedge mclk) disable iff (!rstn)
    trapEvent.divZero || trapEvent.badShift
    |=> tcs_r[tcs_pkg::MATH_BIT])
    else $error("math summary not set");

  // an address fault sets its flag and requests its trap
  AST_ADDR_SET: assert property (
    @(posedge mclk) disable iff (!rstn)
    trapEvent.addrFault
    |=> tcs_r[tcs_pkg::ADDR_BIT] && trapReq.addrTrap)
    else $error("address fault not flagged");

  // a stack fault in the cycle of a clear still lands
  AST_SET_WINS: assert property (
    @(posedge mclk) disable iff (!rstn)
    trapEvent.stackFault && wrCtrl |=> tcs_r[tcs_pkg::STK_BIT])
    else $error("set lost to clear");

  // oscillator failure sets its flag and requests its trap
  AST_OSC_SET: assert property (
    @(posedge mclk) disable iff (!rstn)
    trapEvent.oscFault
    |=> tcs_r[tcs_pkg::OSC_BIT] && trapReq.oscTrap)
    else $error("oscillator fault not flagged");

  // only a core load changes the level register while nesting is disabled
  AST_IPL_LOCK: assert property (
    @(posedge mclk) disable iff (!rstn)
    tcs_r[tcs_pkg::NEST_BIT] && !coreIplLoad |=> $stable(ipl_r))
    else $error("level changed while locked");

  // a flag survives any cycle without a control write
  AST_STICKY: assert property (
    @(posedge mclk) disable iff (!rstn)
    tcs_r[tcs_pkg::ADDR_BIT] && !wrCtrl |=> tcs_r[tcs_pkg::ADDR_BIT])
    else $error("address flag lost");

  // writing zero clears a flag unless an event sets it again
  AST_FLAG_CLR: assert property (
    @(posedge mclk) disable iff (!rstn)
    wrCtrl && !pwdata[tcs_pkg::ADDR_BIT] && !trapEvent.addrFault
    |=> !tcs_r[tcs_pkg::ADDR_BIT])
    else $error("address flag not cleared");

  // an unmasked flag holds the interrupt line high
  AST_IRQ_HIGH: assert property (
    @(posedge mclk) disable iff (!rstn)
    tcs_r[tcs_pkg::ADDR_BIT] && imsk_r[tcs_pkg::ADDR_BIT]
    |-> irq)
    else $error("unmasked flag without interrupt");

  // an unmapped access is refused with an error and no data
  AST_UNMAPPED: assert property (
    @(posedge mclk) disable iff (!rstn)
    acc && !mapped
    |-> pslverr && (prdata == 32'h0000_0000))
    else $error("unmapped access not refused");

  // cover properties for the main scenarios
  COV_MATH: cover property (@(posedge mclk) disable iff (!rstn)
    trapEvent.divZero ##1 tcs_r[tcs_pkg::DIV0_BIT]);
  COV_IRQ: cover property (@(posedge mclk) disable iff (!rstn)
    $rose(irq));
  COV_CLEAR: cover property (@(posedge mclk) disable iff (!rstn)
    tcs_r[tcs_pkg::ADDR_BIT] ##1 !tcs_r[tcs_pkg::ADDR_BIT]);
  COV_LOCK: cover property (@(posedge mclk) disable iff (!rstn)
    wrIpl && tcs_r[tcs_pkg::NEST_BIT]);
  COV_UNMAPPED: cover property (@(posedge mclk) disable iff (!rstn)
    acc && !mapped);
endmodule

/* File: verification/tcs_core_model.sv */
// core and datapath partner model raising trap events and level loads
`timescale 1ns/10ps
module tcs_core_model (
  input  wire logic                mclk,       // system clock
  input  wire logic                rstn,       // async reset, active low
  input  wire logic                go,         // bench asks for a beat
  input  wire tcs_pkg::tcs_event_t evtCmd,     // events of that beat
  input  wire logic [3:0]          iplCmd,     // load flag and level
  output tcs_pkg::tcs_event_t      trapEvent,  // toward the block
  output logic [2:0]               coreIpl,    // level offered
  output logic                     coreIplLoad // level load strobe
);
  // events last only the beats asked for, so each high beat sets again
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      trapEvent   <= '0;
      coreIpl     <= 3'h0;
      coreIplLoad <= 1'b0;
    end else begin
      trapEvent   <= go ? evtCmd : '0;
      coreIplLoad <= go & iplCmd[3];
      // unqualified level shows the inverse, never a stale copy
      coreIpl     <= (go & iplCmd[3]) ? iplCmd[2:0] : ~coreIpl;
    end
  end
endmodule

/* File: verification/tb_top.sv */
// self-checking bench for the trap control and status register
`timescale 1ns/10ps
module tb_top;
  localparam logic [7:0] AC = tcs_pkg::TCS_ADDR_CTRL; // control word
  localparam logic [7:0] AI = tcs_pkg::TCS_ADDR_IPL;  // priority level
  localparam logic [7:0] AM = tcs_pkg::TCS_ADDR_IMSK; // interrupt mask
  // flags expected per event, msb event first; overflows count as math
  localparam logic [15:0] FLG [10] = '{16'h4010, 16'h2010, 16'h1010,
    16'h0810, 16'h0090, 16'h0050, 16'h0020, 16'h0008, 16'h0004, 16'h0002};
  localparam logic [4:0] TRQ [10] = '{5'h10, 5'h10, 5'h10, 5'h10, 5'h10,
    5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
  logic                mclk    = 1'b0;  // 200 mhz clock
  logic                rstn    = 1'b0;  // reset, active low
  logic                psel    = 1'b0;  // apb select
  logic                penable = 1'b0;  // apb access phase
  logic                pwrite  = 1'b0;  // apb direction
  logic [7:0]          paddr   = 8'h00; // apb address
  logic [31:0]         pwdata  = '0;    // apb write data
  logic                go      = 1'b0;  // partner beat request
  logic [3:0]          iplCmd  = 4'h0;  // partner level command
  tcs_pkg::tcs_event_t evtCmd  = '0;    // partner event command
  logic                pready, pslverr, nestingDisable, irq, coreIplLoad;
  logic [31:0]         prdata;          // apb read data
  logic [2:0]          coreIpl, cpuPriorityLevel;
  tcs_pkg::tcs_event_t trapEvent;       // events into the block
  tcs_pkg::tcs_trap_t  trapReq;         // trap requests out
  logic [32:0]         expQ [$];        // notes of {pslverr, prdata}
  int                  num_errors = 0;  // mismatches
  int                  tests_run  = 0;  // comparisons
  logic [2:0]          v;               // random level
  tcs_trap_ctrl uut (.mclk, .rstn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .trapEvent, .coreIpl,
    .coreIplLoad, .trapReq, .nestingDisable, .cpuPriorityLevel, .irq);
  tcs_core_model core (.mclk, .rstn, .go, .evtCmd, .iplCmd, .trapEvent,
    .coreIpl, .coreIplLoad);
  always #2.5 mclk = ~mclk;
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one apb transfer; the answer is noted for the monitor
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    expQ.push_back(e);
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (!pready && n < 20);
    if (!pready) begin
      num_errors++;
      final_report();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask
  // one partner beat; returns at the edge where trap requests stand
  task automatic beat(input logic [9:0] e, input logic [3:0] ic);
    @(posedge mclk);
    go     <= 1'b1;
    evtCmd <= tcs_pkg::tcs_event_t'(e);
    iplCmd <= ic;
    @(posedge mclk);
    go <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  // a finished access takes the oldest note; an empty queue is a fault
  always @(posedge mclk) begin
    if (psel && penable && pready) begin
      if (expQ.size() == 0) check({pslverr, prdata}, 33'h1ffffffff);
      else check({pslverr, prdata}, expQ.pop_front());
    end
  end
  initial begin
    void'($urandom(32'h6e04));
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    rd(AC, 32'h0);
    rd(AI, 32'h0);
    rd(AM, 32'h0);
    $display("test reset done");
    wr(AC, 32'hffffffff);
    rd(AC, 32'h8700);
    check({32'h0, nestingDisable}, 33'h1);
    v = 3'($urandom % 7) + 3'h1;
    wr(AI, {29'h0, v});
    rd(AI, 32'h0);
    beat(10'h0, {1'b1, v});
    rd(AI, {29'h0, v});
    wr(AC, 32'h0);
    wr(AI, {29'h0, ~v});
    rd(AI, {29'h0, ~v});
    check({30'h0, cpuPriorityLevel}, {30'h0, ~v});
    $display("test nesting done");
    beat(10'h3c0, 4'h0);
    check({28'h0, trapReq}, 33'h0);
    rd(AC, 32'h0);
    wr(AC, 32'h0700);
    wr(AM, 32'h78fe);
    for (int i = 0; i < 10; i++) begin
      beat(10'h200 >> i, 4'h0);
      check({28'h0, trapReq}, {28'h0, TRQ[i]});
      check({32'h0, irq}, 33'h1);
      rd(AC, {16'h0, FLG[i] | 16'h0700});
      wr(AC, 32'h0700);
      rd(AC, 32'h0700);
      check({32'h0, irq}, 33'h0);
    end
    $display("test events done");
    wr(AM, 32'h0);
    beat(10'h004, 4'h0);
    check({32'h0, irq}, 33'h0);
    rd(AC, 32'h0708);
    wr(AM, 32'h0008);
    @(posedge mclk);
    check({32'h0, irq}, 33'h1);
    apb(1'b1, 8'h0c, 32'hffffffff, {1'b1, 32'h0});
    apb(1'b0, 8'h0c, 32'h0, {1'b1, 32'h0});
    rd(AC, 32'h0708);
    $display("test mask and unmapped done");
    repeat (2) @(posedge mclk);
    final_report();
  end
endmodule
